// ==== hdl/fpoc_front.v ====
// Operand front end: classification, NaN policy, denormal flushing,
// status/control register and banked register file, reached over APB.
// Assumes an APB master on the same clock and a synchronous reset.
//
// The placing of the registers and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "fpoc_consts.vh"
module fpoc_front (
    input wire clock,
    input wire reset,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    output reg disableExc,
    output reg invalidExc
);
    // ======================================================================
    // Helpers
    // ======================================================================
    // Class of a single operand.
    function [2:0] classSp;
        input [31:0] v;
        begin
            if (&v[30:23]) begin
                if (v[22:0] == 23'h000000)
                    classSp = `FPOC_CLS_INF;
                else if (v[22])
                    classSp = `FPOC_CLS_SIGNALING_NAN;
                else
                    classSp = `FPOC_CLS_QUIET_NAN;
            end else if (v[30:23] == 8'h00) begin
                if (v[22:0] == 23'h000000)
                    classSp = `FPOC_CLS_ZERO;
                else
                    classSp = `FPOC_CLS_DENORM;
            end else begin
                classSp = `FPOC_CLS_NORMAL;
            end
        end
    endfunction

    // Class of a double operand.
    function [2:0] classDp;
        input [63:0] v;
        begin
            if (&v[62:52]) begin
                if (v[51:0] == 52'h0000000000000)
                    classDp = `FPOC_CLS_INF;
                else if (v[51])
                    classDp = `FPOC_CLS_SIGNALING_NAN;
                else
                    classDp = `FPOC_CLS_QUIET_NAN;
            end else if (v[62:52] == 11'h000) begin
                if (v[51:0] == 52'h0000000000000)
                    classDp = `FPOC_CLS_ZERO;
                else
                    classDp = `FPOC_CLS_DENORM;
            end else begin
                classDp = `FPOC_CLS_NORMAL;
            end
        end
    endfunction

    // Physical index for a single name, plain or extended view.
    function [4:0] physIdx;
        input bankSel;
        input extended;
        input [3:0] name;
        begin
            physIdx = {bankSel ^ extended, name};
        end
    endfunction

    // ======================================================================
    // Registers
    // ======================================================================
    reg [31:0] scr_q;
    reg [31:0] cpuWord_q;
    reg [31:0] cmd_q;
    reg [63:0] opA_q;
    reg [63:0] opB_q;
    reg [63:0] res_q;
    reg [7:0] stat_q;

    wire setupWr = psel && !penable && pwrite;
    wire accessWr = psel && penable && pwrite;
    wire accessRd = psel && penable && !pwrite;
    wire bankSel = scr_q[`FPOC_SCR_BANK];
    wire flushMode = scr_q[`FPOC_SCR_FLUSH];
    wire invEnable = scr_q[`FPOC_ENABLE_LO + `FPOC_EXC_V];
    wire unitOff = cpuWord_q[`FPOC_CPUSW_DISABLE];

    assign pready = 1'b1;
    assign pslverr = 1'b0;

    // ======================================================================
    // Command decode
    // ======================================================================
    // cmd: [2:0] op, [3] double, [4] extended view, [8:5] dest name,
    // [9] load opA from bank, [10] store result to bank.
    wire [2:0] cmdOp = pwdata[2:0];
    wire cmdDouble = pwdata[3];
    wire cmdExt = pwdata[4];
    wire [3:0] cmdName = pwdata[8:5];
    wire cmdLoad = pwdata[9];
    wire cmdStore = pwdata[10];
    wire cmdIssue = accessWr && (paddr == `FPOC_ADDR_CMD);

    wire [2:0] clsA = cmdDouble ? classDp(opA_q) : classSp(opA_q[31:0]);
    wire [2:0] clsB = cmdDouble ? classDp(opB_q) : classSp(opB_q[31:0]);
    wire valueOp = (cmdOp == `FPOC_OP_ARITH);
    wire anySnan = (clsA == `FPOC_CLS_SIGNALING_NAN) || (clsB == `FPOC_CLS_SIGNALING_NAN);
    wire anyQnan = (clsA == `FPOC_CLS_QUIET_NAN) || (clsB == `FPOC_CLS_QUIET_NAN);

    // Flushed operand A; the arithmetic core sits outside this block, so
    // the value-producing path passes the flushed operand A through.
    reg [63:0] flushA;
    reg [63:0] result;
    reg raiseInv;
    always @* begin
        flushA = opA_q;
        if (valueOp && flushMode && (clsA == `FPOC_CLS_DENORM)) begin
            if (cmdDouble)
                flushA = {opA_q[63], 63'h0};
            else
                flushA = {32'h0, opA_q[31], 31'h0};
        end
        raiseInv = 1'b0;
        case (cmdOp)
            `FPOC_OP_ABS: result = cmdDouble ? {1'b0, opA_q[62:0]} :
                {32'h0, 1'b0, opA_q[30:0]};
            `FPOC_OP_NEG: result = cmdDouble ? {~opA_q[63], opA_q[62:0]} :
                {32'h0, ~opA_q[31], opA_q[30:0]};
            `FPOC_OP_ARITH: begin
                result = flushA;
                if (anySnan && invEnable)
                    raiseInv = 1'b1;
                if (anySnan || anyQnan)
                    result = cmdDouble ? `FPOC_QUIET_NAN_DP :
                        {32'h0, `FPOC_QUIET_NAN_SP};
            end
            default: result = opA_q;
        endcase
    end

    // ======================================================================
    // Bank access: sequencer for loads and stores of 1..2 words
    // ======================================================================
    localparam ST_IDLE = 3'b001;
    localparam ST_RD = 3'b010;
    localparam ST_WR = 3'b100;
    reg [2:0] state_q;
    reg [1:0] step_q;
    reg [4:0] baseIdx_q;
    reg pairMode_q;

    wire [4:0] apbIdx = physIdx(bankSel, paddr[6], paddr[5:2]);
    wire bankHit = paddr[7];
    wire opAccepted = cmdIssue && !unitOff && !(raiseInv);

    reg memWe;
    reg [4:0] memWa;
    reg [31:0] memWd;
    reg [4:0] memRa;
    wire [31:0] memRd;
    always @* begin
        memWe = 1'b0;
        memWa = apbIdx;
        memWd = pwdata;
        memRa = apbIdx;
        if (state_q == ST_WR) begin
            memWe = 1'b1;
            memWa = baseIdx_q | {4'h0, step_q[0]};
            memWd = (pairMode_q && !step_q[0]) ?
                res_q[63:32] : res_q[31:0];
            if (!pairMode_q)
                memWd = res_q[31:0];
        end else if (state_q == ST_RD) begin
            memRa = baseIdx_q | {4'h0, step_q[0]};
        end else if (accessWr && bankHit) begin
            memWe = 1'b1;
        end
    end

    fpoc_bank_mem #(
        .WIDTH(32),
        .DEPTH(32),
        .AW(5)
    ) bankMem (
        .clock(clock),
        .writeEn(memWe),
        .writeAddr(memWa),
        .writeData(memWd),
        .readAddr(memRa),
        .readData(memRd)
    );

    reg rdPend_q;
    always @(posedge clock) begin
        if (reset) begin
            scr_q <= `FPOC_SCR_RESET;
            cpuWord_q <= 32'h00000000;
            cmd_q <= 32'h00000000;
            opA_q <= 64'h0;
            opB_q <= 64'h0;
            res_q <= 64'h0;
            stat_q <= 8'h00;
            disableExc <= 1'b0;
            invalidExc <= 1'b0;
            state_q <= ST_IDLE;
            step_q <= 2'h0;
            baseIdx_q <= 5'h00;
            pairMode_q <= 1'b0;
            rdPend_q <= 1'b0;
        end else begin
            disableExc <= 1'b0;
            invalidExc <= 1'b0;
            rdPend_q <= setupWr ? 1'b0 : (psel && !penable);
            if (accessWr && !bankHit) begin
                case (paddr)
                    `FPOC_ADDR_SCR: scr_q <= pwdata & `FPOC_SCR_MASK;
                    `FPOC_ADDR_CPUSW: cpuWord_q <= pwdata;
                    `FPOC_ADDR_OPA_HI: opA_q[63:32] <= pwdata;
                    `FPOC_ADDR_OPA_LO: opA_q[31:0] <= pwdata;
                    `FPOC_ADDR_OPB_HI: opB_q[63:32] <= pwdata;
                    `FPOC_ADDR_OPB_LO: opB_q[31:0] <= pwdata;
                    `FPOC_ADDR_STAT: stat_q <= stat_q & ~pwdata[7:0];
                    default: ;
                endcase
            end
            if (cmdIssue) begin
                cmd_q <= pwdata;
                // The cause field clears at the start of each instruction.
                scr_q[17:12] <= 6'h00;
                if (unitOff) begin
                    disableExc <= 1'b1;
                    stat_q[0] <= 1'b1;
                end else if (raiseInv) begin
                    invalidExc <= 1'b1;
                    stat_q[1] <= 1'b1;
                    scr_q[`FPOC_CAUSE_LO + `FPOC_EXC_V] <= 1'b1;
                    scr_q[`FPOC_FLAG_LO + `FPOC_EXC_V] <= 1'b1;
                end else begin
                    res_q <= result;
                    if (cmdLoad) begin
                        state_q <= ST_RD;
                        step_q <= 2'h0;
                        baseIdx_q <= physIdx(bankSel, cmdExt,
                            cmdDouble ? {cmdName[3:1], 1'b0} : cmdName);
                        pairMode_q <= cmdDouble;
                    end else if (cmdStore) begin
                        state_q <= ST_WR;
                        step_q <= 2'h0;
                        baseIdx_q <= physIdx(bankSel, cmdExt,
                            cmdDouble ? {cmdName[3:1], 1'b0} : cmdName);
                        pairMode_q <= cmdDouble;
                    end
                end
            end
            case (state_q)
                ST_IDLE: ;
                ST_WR: begin
                    if (pairMode_q && !step_q[0]) begin
                        step_q <= 2'h1;
                    end else begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_RD: begin
                    step_q <= step_q + 2'h1;
                    if (step_q == 2'h1 && pairMode_q)
                        opA_q[63:32] <= memRd;
                    else if (step_q == 2'h1)
                        opA_q <= {32'h0, memRd};
                    if (step_q == 2'h2) begin
                        opA_q[31:0] <= memRd;
                        state_q <= ST_IDLE;
                    end else if (step_q == 2'h1 && !pairMode_q) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // ======================================================================
    // Read mux: bank reads use the bank window at word strides.
    // ======================================================================
    always @* begin
        case (paddr)
            `FPOC_ADDR_SCR: prdata = scr_q;
            `FPOC_ADDR_CMD: prdata = cmd_q;
            `FPOC_ADDR_OPA_HI: prdata = opA_q[63:32];
            `FPOC_ADDR_OPA_LO: prdata = opA_q[31:0];
            `FPOC_ADDR_OPB_HI: prdata = opB_q[63:32];
            `FPOC_ADDR_OPB_LO: prdata = opB_q[31:0];
            `FPOC_ADDR_RES_HI: prdata = res_q[63:32];
            `FPOC_ADDR_RES_LO: prdata = res_q[31:0];
            `FPOC_ADDR_STAT: prdata = {24'h0, stat_q};
            `FPOC_ADDR_CPUSW: prdata = cpuWord_q;
            default: prdata = bankHit ? memRd : 32'h00000000;
        endcase
    end
endmodule // fpoc_front

// ==== hdl/fpoc_consts.vh ====
// Constants for the floating-point operand front end and register bank.
// Assumes inclusion by bare name from each file of the block that uses it.
`ifndef FPOC_CONSTS_VH
`define FPOC_CONSTS_VH

// ==========================================================================
// APB register map
// ==========================================================================
`define FPOC_ADDR_SCR 8'h00
`define FPOC_ADDR_CMD 8'h04
`define FPOC_ADDR_OPA_HI 8'h08
`define FPOC_ADDR_OPA_LO 8'h0C
`define FPOC_ADDR_OPB_HI 8'h10
`define FPOC_ADDR_OPB_LO 8'h14
`define FPOC_ADDR_RES_HI 8'h18
`define FPOC_ADDR_RES_LO 8'h1C
`define FPOC_ADDR_STAT 8'h20
`define FPOC_ADDR_CPUSW 8'h24
`define FPOC_ADDR_BANK 8'h80

// ==========================================================================
// Status/control register fields
// ==========================================================================
`define FPOC_SCR_RESET 32'h00040001
`define FPOC_SCR_MASK 32'h003FFFFF
`define FPOC_SCR_BANK 21
`define FPOC_SCR_FLUSH 18
`define FPOC_CAUSE_LO 12
`define FPOC_ENABLE_LO 7
`define FPOC_FLAG_LO 2
`define FPOC_EXC_V 4
`define FPOC_CPUSW_DISABLE 15

// ==========================================================================
// Number formats
// ==========================================================================
`define FPOC_SP_EXP_W 8
`define FPOC_SP_FRAC_W 23
`define FPOC_DP_EXP_W 11
`define FPOC_DP_FRAC_W 52
`define FPOC_QUIET_NAN_SP 32'h7FBFFFFF
`define FPOC_QUIET_NAN_DP 64'h7FF7FFFFFFFFFFFF

// Classes.
`define FPOC_CLS_ZERO 3'h0
`define FPOC_CLS_DENORM 3'h1
`define FPOC_CLS_NORMAL 3'h2
`define FPOC_CLS_INF 3'h3
`define FPOC_CLS_QUIET_NAN 3'h4
`define FPOC_CLS_SIGNALING_NAN 3'h5

// Operation codes in the command register.
`define FPOC_OP_COPY 3'h0
`define FPOC_OP_ABS 3'h1
`define FPOC_OP_NEG 3'h2
`define FPOC_OP_ARITH 3'h3

`endif

// ==== hdl/fpoc_bank_mem.v ====
// Physical floating-point register bank: 32 words of 32 bits.
// Assumes one writer per cycle and a registered read port.
`timescale 1ns/1ps
module fpoc_bank_mem #(
    parameter WIDTH = 32,
    parameter DEPTH = 32,
    parameter AW = 5
) (
    input wire clock,
    input wire writeEn,
    input wire [AW-1:0] writeAddr,
    input wire [WIDTH-1:0] writeData,
    input wire [AW-1:0] readAddr,
    output reg [WIDTH-1:0] readData
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];

    always @(posedge clock) begin
        if (writeEn) begin
            mem[writeAddr] <= writeData;
        end
        readData <= mem[readAddr];
    end
endmodule // fpoc_bank_mem

// ==== bench/fpoc_front_chk.sv ====
// Checker for the operand front end, watching its APB and exception ports.
// Assumes the constants header is on the include path.
`timescale 1ns/1ps
`include "fpoc_consts.vh"
module fpoc_front_chk (
    input wire clock,
    input wire reset,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire disableExc,
    input wire invalidExc
);
    // ======================================================================
    // Shadow of the control state written by software
    // ======================================================================
    reg [31:0] scr_q;
    reg unitOff_q;
    wire wrEn = psel && penable && pwrite;
    wire rdEn = psel && penable && !pwrite;
    wire cmdWr = wrEn && paddr == `FPOC_ADDR_CMD;
    always @(posedge clock) begin
        if (reset) begin
            scr_q <= `FPOC_SCR_RESET;
            unitOff_q <= 1'b0;
        end else begin
            if (wrEn && paddr == `FPOC_ADDR_SCR) begin
                scr_q <= pwdata & `FPOC_SCR_MASK;
            end
            if (wrEn && paddr == `FPOC_ADDR_CPUSW) begin
                unitOff_q <= pwdata[`FPOC_CPUSW_DISABLE];
            end
        end
    end
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);
    a_scr_read: assert property (rdEn && paddr == `FPOC_ADDR_SCR
        |-> prdata == scr_q) else $error("control register read differs");
    a_disable_raise: assert property (cmdWr && unitOff_q
        |=> disableExc) else $error("disabled command not refused");
    a_disable_cause: assert property (disableExc
        |-> $past(cmdWr) && $past(unitOff_q)) else $error("stray disable");
    a_disable_pulse: assert property (disableExc
        |=> !disableExc) else $error("disable pulse too long");
    a_invalid_cause: assert property (invalidExc
        |-> $past(cmdWr) && $past(scr_q[11]) && !$past(unitOff_q))
        else $error("invalid raised without enable");
    a_quiet_cmd: assert property (cmdWr && !unitOff_q && !scr_q[11]
        |=> !disableExc && !invalidExc) else $error("exception not expected");
    a_cpusw_read: assert property (rdEn && paddr == `FPOC_ADDR_CPUSW
        |-> prdata[15] == unitOff_q) else $error("unit disable bit differs");
    a_exc_exclusive: assert property (!(disableExc && invalidExc))
        else $error("both exceptions at once");
    a_zero_wait: assert property (psel && penable |-> pready && !pslverr)
        else $error("access not completed at once");
    c_disable: cover property (disableExc);
    c_invalid: cover property (invalidExc);
    c_bank_read: cover property (rdEn && paddr[7]);
endmodule // fpoc_front_chk
bind fpoc_front fpoc_front_chk i_fpoc_front_chk (.clock(clock),
    .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .disableExc(disableExc), .invalidExc(invalidExc));

// ==== bench/fpoc_cpu_model.sv ====
// Core-side model issuing floating-point commands as APB transfers.
// Assumes the bench calls xfer only just after a rising clock edge.
`timescale 1ns/1ps
module fpoc_cpu_model (
    input wire clock,
    input wire pready,
    output reg psel,
    output reg penable,
    output reg pwrite,
    output reg [7:0] paddr,
    output reg [31:0] pwdata,
    output reg chkRd,
    output reg stuck
);
    // ======================================================================
    // One APB transfer, released with inverted lines and an idle cycle
    // ======================================================================
    initial begin
        {psel, penable, pwrite, chkRd, stuck} = 5'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    task xfer(input w, input [7:0] a, input [31:0] d, input chk);
        integer n;
        begin
            psel <= 1'b1;
            penable <= 1'b0;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            chkRd <= chk;
            @(posedge clock);
            penable <= 1'b1;
            n = 0;
            @(posedge clock);
            while (!pready && n < 20) begin
                n = n + 1;
                @(posedge clock);
            end
            if (!pready) stuck <= 1'b1;
            psel <= 1'b0;
            penable <= 1'b0;
            chkRd <= 1'b0;
            paddr <= ~a;
            pwdata <= ~d;
            @(posedge clock);
        end
    endtask
endmodule // fpoc_cpu_model

// ==== bench/fpoc_front_tb.sv ====
// Self-checking bench for the operand front end and its register bank.
// Assumes the constants header is on the include path.
`timescale 1ns/1ps
`include "fpoc_consts.vh"
module fpoc_front_tb;
    reg clock = 1'b0;
    reg reset = 1'b1;
    wire psel, penable, pwrite, pready, pslverr, chkRd, stuck;
    wire disableExc, invalidExc;
    wire [7:0] paddr;
    wire [31:0] pwdata, prdata;
    integer fails = 0, compares = 0, dExcN = 0, iExcN = 0, i;
    reg [31:0] seed = 32'd68123;
    reg [31:0] expQ[$];
    reg [31:0] sN, qN, dn, w, a, e, s;
    reg [2:0] o;
    always #10 clock = ~clock;
    fpoc_front i_fpoc_front (.clock(clock), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .disableExc(disableExc), .invalidExc(invalidExc));
    fpoc_cpu_model u_cpu (.clock(clock), .pready(pready), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .chkRd(chkRd), .stuck(stuck));
    // ======================================================================
    // Helpers and result monitor
    // ======================================================================
    function automatic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task check(input [63:0] seen, input [63:0] exp);
        begin
            compares = compares + 1;
            if (seen !== exp) begin
                fails = fails + 1;
                $display("Error at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task end_sim;
        begin
            $display("compares %0d fails %0d", compares, fails);
            if (fails == 0 && compares > 0) $display("*** PASS ***");
            else $display("*** FAIL ***");
            $finish;
        end
    endtask
    task wr(input [7:0] ad, input [31:0] d);
        u_cpu.xfer(1'b1, ad, d, 1'b0);
    endtask
    task rd(input [7:0] ad, input [31:0] ev);
        begin
            expQ.push_back(ev);
            u_cpu.xfer(1'b0, ad, 32'h0, 1'b1);
        end
    endtask
    // Commands are spaced by four idle cycles so stores can settle.
    task op(input [2:0] oc, input dbl, input [3:0] nm, input st);
        begin
            wr(`FPOC_ADDR_CMD, {21'h0, st, 1'b0, nm, 1'b0, dbl, oc});
            repeat (3) @(posedge clock);
        end
    endtask
    always @(posedge clock) begin
        if (psel && penable && pready && !pwrite && chkRd)
            check(prdata, expQ.pop_front());
        if (!reset) begin
            dExcN = dExcN + disableExc;
            iExcN = iExcN + invalidExc;
        end
        if (stuck) begin
            fails = fails + 1;
            end_sim;
        end
    end
    // ======================================================================
    // Main sequence
    // ======================================================================
    initial begin
        repeat (3) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        @(posedge clock);
        rd(`FPOC_ADDR_SCR, 32'h00040001);
        rd(8'h28, 32'h0);
        sN = 32'h7FC00000 | (rnd() & 32'h803FFFFF);
        qN = 32'h7F800001 | (rnd() & 32'h803FFFFF);
        dn = 32'h00000001 | (rnd() & 32'h007FFFFF);
        for (i = 0; i < 10; i = i + 1) begin
            case (i)
                0: {s, o, a, e} = {32'h1, 3'h3, sN, 32'h7FBFFFFF};
                1: {s, o, a, e} = {32'h1, 3'h3, qN, 32'h7FBFFFFF};
                2: {s, o, a, e} = {32'h801, 3'h3, qN, 32'h7FBFFFFF};
                3: {s, o, a, e} = {32'h1, 3'h1, sN | 32'h80000000,
                    sN & 32'h7FFFFFFF};
                4: {s, o, a, e} = {32'h1, 3'h2, sN & 32'h7FFFFFFF,
                    sN | 32'h80000000};
                5: {s, o, a, e} = {32'h40001, 3'h3, dn, 32'h0};
                6: {s, o, a, e} = {32'h40001, 3'h0, dn, dn};
                7: {s, o, a, e} = {32'h1, 3'h3, dn, dn};
                8: {s, o, a, e} = {32'h40001, 3'h3, 32'h7F800000, 32'h7F800000};
                default: {s, o, a, e} = {32'h40001, 3'h3, 32'h3F800000,
                    32'h3F800000};
            endcase
            wr(`FPOC_ADDR_SCR, s);
            wr(`FPOC_ADDR_OPA_LO, a);
            op(o, 1'b0, 4'h0, 1'b0);
            rd(`FPOC_ADDR_RES_LO, e);
        end
        w = rnd();
        a = rnd();
        wr(`FPOC_ADDR_SCR, 32'h00040001);
        wr(`FPOC_ADDR_OPA_LO, w);
        op(3'h0, 1'b0, 4'h5, 1'b1);
        wr(`FPOC_ADDR_SCR, 32'h00240001);
        wr(`FPOC_ADDR_OPA_LO, a);
        op(3'h0, 1'b0, 4'h5, 1'b1);
        rd(8'h94, a);
        rd(8'hD4, w);
        wr(`FPOC_ADDR_SCR, 32'h00040001);
        rd(8'h94, w);
        rd(8'hD4, a);
        wr(`FPOC_ADDR_OPA_HI, w);
        wr(`FPOC_ADDR_OPA_LO, a);
        op(3'h0, 1'b1, 4'h2, 1'b1);
        rd(8'h88, w);
        rd(8'h8C, a);
        wr(`FPOC_ADDR_OPA_HI, 32'h0);
        wr(`FPOC_ADDR_OPA_LO, 32'h0);
        // Load the pair named 2 back into operand A.
        wr(`FPOC_ADDR_CMD, 32'h00000248);
        repeat (3) @(posedge clock);
        rd(`FPOC_ADDR_OPA_HI, w);
        rd(`FPOC_ADDR_OPA_LO, a);
        wr(`FPOC_ADDR_OPA_HI, 32'h7FF80000 | (rnd() & 32'h8007FFFF));
        op(3'h3, 1'b1, 4'h0, 1'b0);
        rd(`FPOC_ADDR_RES_HI, 32'h7FF7FFFF);
        rd(`FPOC_ADDR_RES_LO, 32'hFFFFFFFF);
        wr(`FPOC_ADDR_SCR, 32'h00000801);
        wr(`FPOC_ADDR_OPA_LO, w);
        op(3'h0, 1'b0, 4'h0, 1'b0);
        wr(`FPOC_ADDR_OPA_LO, sN);
        op(3'h3, 1'b0, 4'h0, 1'b0);
        rd(`FPOC_ADDR_RES_LO, w);
        check(iExcN, 1);
        rd(`FPOC_ADDR_STAT, 32'h2);
        wr(`FPOC_ADDR_CPUSW, 32'h00008000);
        wr(`FPOC_ADDR_OPA_LO, a);
        op(3'h0, 1'b0, 4'h0, 1'b0);
        rd(`FPOC_ADDR_RES_LO, w);
        check(dExcN, 1);
        rd(`FPOC_ADDR_STAT, 32'h3);
        wr(`FPOC_ADDR_CPUSW, 32'h0);
        wr(`FPOC_ADDR_STAT, 32'h3);
        rd(`FPOC_ADDR_STAT, 32'h0);
        op(3'h0, 1'b0, 4'h0, 1'b0);
        rd(`FPOC_ADDR_RES_LO, a);
        check(dExcN, 1);
        end_sim;
    end
endmodule // fpoc_front_tb
